// ===== nco_bank_pkg.sv
// Package with register map, reset values, carriers and counts for the tuning word bank.
//------------------------------------------------------------------------------
// Function
// - Accumulator adds active word every sample clock.
// - Accumulator wraps modulo two to sixty-four.
// - Written word waits until selected sync event.
// - Fast reconfiguration overrides register words.
// - Oscillator 0 word at 0x320, resets zero.
// - Oscillator 1 word at 0x328, resets zero.
// - Oscillator 2 word at 0x330, resets zero.
// - Software sync rising write raises bound events.
// - Periodic self sync every 256 cycles.
//------------------------------------------------------------------------------
package nco_bank_pkg;

  localparam int          NUM_OSC      = 3;
  localparam int          WORD_W       = 64;
  localparam int          ADDR_W       = 12;

  // Register offsets; the two 32-bit halves of each word sit at +0 and +4.
  localparam logic [11:0] OFF_NCO0     = 12'h320;
  localparam logic [11:0] OFF_NCO1     = 12'h328;
  localparam logic [11:0] OFF_NCO2     = 12'h330;
  localparam logic [11:0] OFF_SW_SYNC  = 12'h304;
  localparam logic [11:0] OFF_SELF_SYN = 12'h305;
  localparam logic [11:0] OFF_CONTROL  = 12'h340;
  localparam logic [11:0] OFF_STATUS   = 12'h344;

  localparam logic [63:0] WORD_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [7:0]  PERIOD_CYCLES = 8'hFF;

  // Fields of the control register.
  localparam int          CTL_SEL_LSB  = 0;
  localparam int          CTL_DATAPATH_ENABLE    = 4;
  localparam int          CTL_FAST_RECONFIG_ENABLE    = 5;

  typedef enum logic [1:0] {
    TRIG_SW_SYNC  = 2'b00,
    TRIG_EXTERNAL = 2'b01,
    TRIG_BOTH     = 2'b10,
    TRIG_NONE     = 2'b11
  } trigger_select_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef logic [WORD_W-1:0] word_t;

endpackage

// ===== nco_frequency_word_bank.sv
// Tuning word bank with shadow and active words and three phase accumulators.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module nco_frequency_word_bank
  import nco_bank_pkg::*;
(
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset_n,
  // Register port
  input  wire logic [11:0]                i_addr,
  input  wire logic [31:0]                i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [31:0]                o_rdata,
  // Sync and fast reconfiguration
  input  wire logic                       i_ext_sync,
  input  wire logic [NUM_OSC*WORD_W-1:0]  i_fast_words,
  // Oscillator outputs
  output logic      [NUM_OSC*WORD_W-1:0]  o_phase,
  output logic                            o_sync_pulse
);

  //----------------------------------------------------------------------------
  // Register state
  //----------------------------------------------------------------------------
  word_t           shadow      [NUM_OSC];
  word_t           active      [NUM_OSC];
  word_t           next_shadow [NUM_OSC];
  word_t           next_active [NUM_OSC];
  word_t           acc         [NUM_OSC];
  word_t           next_acc    [NUM_OSC];
  logic            sw_sync;
  logic            next_sw_sync;
  logic            self_sync;
  logic            next_self_sync;
  logic [5:0]      control;
  logic [5:0]      next_control;
  logic [7:0]      period_cnt;
  logic [7:0]      next_period_cnt;
  logic [31:0]     next_rdata;
  logic            sync_event;
  logic            sw_edge;
  logic [7:0]      sync_count;
  logic [7:0]      next_sync_count;
  reg_req_t        req;
  trigger_select_t trig_sel;

  assign req      = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign trig_sel = trigger_select_t'(control[CTL_SEL_LSB +: 2]);

  // Index of the word addressed by either half, or NUM_OSC when none matches.
  function automatic logic [1:0] word_index(input logic [11:0] a);
    logic [1:0] idx;
    idx = 2'(NUM_OSC);
    if ({a[11:3], 3'b000} == OFF_NCO0) begin
      idx = 2'd0;
    end else if ({a[11:3], 3'b000} == OFF_NCO1) begin
      idx = 2'd1;
    end else if ({a[11:3], 3'b000} == OFF_NCO2) begin
      idx = 2'd2;
    end
    return idx;
  endfunction

  //----------------------------------------------------------------------------
  // Sync event
  //----------------------------------------------------------------------------
  // A software sync fires only on a write of one over a stored zero.
  assign sw_edge = req.wr && (req.addr == OFF_SW_SYNC) && req.wdata[0] && !sw_sync;

  always_comb begin
    case (trig_sel)
      TRIG_SW_SYNC:  sync_event = sw_edge;
      TRIG_EXTERNAL: sync_event = i_ext_sync;
      TRIG_BOTH:     sync_event = sw_edge | i_ext_sync;
      TRIG_NONE:     sync_event = 1'b0;
      default:       sync_event = 1'b0;
    endcase
    // Periodic self sync moves every pending word at once.
    if (self_sync && period_cnt == PERIOD_CYCLES) begin
      sync_event = 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb begin
    logic [1:0] widx;
    widx            = word_index(req.addr);
    next_sw_sync    = sw_sync;
    next_self_sync  = self_sync;
    next_control    = control;
    next_period_cnt = self_sync ? period_cnt + 8'h01 : 8'h00;
    next_sync_count = sync_count + {7'h00, sync_event};
    next_rdata      = 32'h0000_0000;
    for (int n = 0; n < NUM_OSC; n++) begin
      next_shadow[n] = shadow[n];
      // The active copy only moves on the chosen sync event.
      next_active[n] = sync_event ? shadow[n] : active[n];
      // Fast reconfiguration replaces the programmed word.
      next_acc[n] = acc[n] + (control[CTL_FAST_RECONFIG_ENABLE] ? i_fast_words[n*WORD_W +: WORD_W]
                                                 : active[n]);
    end
    if (req.wr) begin
      if (widx != 2'(NUM_OSC)) begin
        if (req.addr[2]) begin
          next_shadow[widx][63:32] = req.wdata;
        end else begin
          next_shadow[widx][31:0]  = req.wdata;
        end
      end
      case (req.addr)
        OFF_SW_SYNC:  next_sw_sync   = req.wdata[0];
        OFF_SELF_SYN: next_self_sync = req.wdata[0];
        OFF_CONTROL:  next_control   = req.wdata[5:0];
        default:      next_control   = next_control;
      endcase
    end
    if (req.rd) begin
      if (widx != 2'(NUM_OSC)) begin
        next_rdata = req.addr[2] ? shadow[widx][63:32] : shadow[widx][31:0];
      end else begin
        case (req.addr)
          OFF_SW_SYNC:  next_rdata = {31'h0000_0000, sw_sync};
          OFF_SELF_SYN: next_rdata = {31'h0000_0000, self_sync};
          OFF_CONTROL:  next_rdata = {26'h000_0000, control};
          OFF_STATUS:   next_rdata = {16'h0000, period_cnt, sync_count};
          default:      next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int n = 0; n < NUM_OSC; n++) begin
        shadow[n] <= WORD_RESET;
        active[n] <= WORD_RESET;
        acc[n]    <= WORD_RESET;
      end
      sw_sync      <= 1'b0;
      self_sync    <= 1'b0;
      control      <= 6'h00;
      period_cnt   <= 8'h00;
      sync_count   <= 8'h00;
      o_rdata      <= 32'h0000_0000;
      o_sync_pulse <= 1'b0;
    end else begin
      for (int n = 0; n < NUM_OSC; n++) begin
        shadow[n] <= next_shadow[n];
        active[n] <= next_active[n];
        acc[n]    <= next_acc[n];
      end
      sw_sync      <= next_sw_sync;
      self_sync    <= next_self_sync;
      control      <= next_control;
      period_cnt   <= next_period_cnt;
      sync_count   <= next_sync_count;
      o_rdata      <= next_rdata;
      o_sync_pulse <= sync_event;
    end
  end

  generate
    for (genvar g = 0; g < NUM_OSC; g++) begin : g_phase
      assign o_phase[g*WORD_W +: WORD_W] = acc[g];
    end
  endgenerate

endmodule // nco_frequency_word_bank

// ===== nco_frequency_word_bank_sva.sv
// Port checker for the tuning word bank.
`timescale 1ns/1ps
module nco_frequency_word_bank_sva
  import nco_bank_pkg::*;
(
  input wire logic                      i_core_clk,
  input wire logic                      i_reset_n,
  input wire logic [11:0]               i_addr,
  input wire logic [31:0]               i_wdata,
  input wire logic                      i_wr,
  input wire logic                      i_rd,
  input wire logic [31:0]               o_rdata,
  input wire logic                      i_ext_sync,
  input wire logic [NUM_OSC*WORD_W-1:0] i_fast_words,
  input wire logic [NUM_OSC*WORD_W-1:0] o_phase,
  input wire logic                      o_sync_pulse
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  wire cw = i_wr && i_addr == OFF_CONTROL;
  property p_rb(logic [11:0] a, logic [31:0] m);
    i_wr && i_addr == a ##1 i_rd && i_addr == a |=> (o_rdata & m) == ($past(i_wdata, 2) & m);
  endproperty
  // The step may only move after a sync, a control write or new fast words.
  property p_step;
    !o_sync_pulse && !$past(o_sync_pulse) && !$past(cw) && !$past(cw, 2)
      && $past(i_fast_words) == $past(i_fast_words, 2)
      |-> o_phase[63:0] - $past(o_phase[63:0])
      == $past(o_phase[63:0]) - $past(o_phase[63:0], 2);
  endproperty
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero when idle");
  chk_unmapped_zero: assert property (i_rd && i_addr == 12'h310 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_word0_back: assert property (p_rb(OFF_NCO0, 32'hFFFFFFFF))
    else $error("word 0 readback wrong");
  chk_word1_back: assert property (p_rb(OFF_NCO1 + 12'h4, 32'hFFFFFFFF))
    else $error("word 1 readback wrong");
  chk_word2_back: assert property (p_rb(OFF_NCO2 + 12'h4, 32'hFFFFFFFF))
    else $error("word 2 readback wrong");
  chk_sync_back: assert property (p_rb(OFF_SW_SYNC, 32'h1))
    else $error("sync bit readback wrong");
  chk_self_back: assert property (p_rb(OFF_SELF_SYN, 32'h1))
    else $error("self sync bit readback wrong");
  chk_step_held: assert property (p_step)
    else $error("phase step changed without sync");
  cover property (o_sync_pulse);
  cover property (i_ext_sync ##1 o_sync_pulse);
  cover property (i_rd && i_addr == OFF_NCO2);
endmodule // nco_frequency_word_bank_sva

bind nco_frequency_word_bank nco_frequency_word_bank_sva i_sva (.i_core_clk, .i_reset_n,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_sync, .i_fast_words, .o_phase, .o_sync_pulse);

// ===== tb_nco_frequency_word_bank.sv
// Self-checking bench for the tuning word bank.
`timescale 1ns/1ps
module tb_nco_frequency_word_bank import nco_bank_pkg::*;;
  logic        i_core_clk = 0, i_reset_n, i_wr, i_rd, i_ext_sync, o_sync_pulse, sw, ss, fr, pl;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [191:0] i_fast_words, o_phase;
  logic [63:0] sh[3], ac[3], ph[3], d;
  logic [1:0]  sel;
  logic [7:0]  cnt;
  int          n_fail = 0, samples_checked = 0, s;
  always #2.5 i_core_clk = ~i_core_clk;
  nco_frequency_word_bank i_nco_frequency_word_bank (.i_core_clk, .i_reset_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_sync, .i_fast_words, .o_phase, .o_sync_pulse);
  task automatic chk(string n, logic [191:0] e, logic [191:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Strobes stay up across back-to-back calls; idle() is what drops them.
  task automatic wr(logic [11:0] a, logic [31:0] v);
    {i_wr, i_rd, i_addr, i_wdata} <= {2'b10, a, v};
    @(posedge i_core_clk);
  endtask
  task automatic rdr(logic [11:0] a);
    {i_wr, i_rd, i_addr} <= {2'b01, a};
    @(posedge i_core_clk);
  endtask
  task automatic idle(int n);
    {i_wr, i_rd} <= 2'b00;
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Model sees the strobes before this edge's bench updates land.
  always @(posedge i_core_clk or negedge i_reset_n) begin : mdl
    logic ev;
    if (!i_reset_n) begin
      sh = '{3{64'h0}};
      ac = sh;
      ph = sh;
      {sel, sw, ss, fr, pl, cnt, rd} = '0;
    end else begin
      for (int k = 0; k < 3; k++) ph[k] += fr ? i_fast_words[k*64+:64] : ac[k];
      ev = (i_ext_sync && sel inside {1, 2}) || (ss && cnt == 8'hFF);
      cnt += ss;
      rd = 0;
      for (int k = 0; k < 6; k++) begin
        if (i_rd && i_addr == OFF_NCO0 + 4*k) rd = sh[k/2][k%2*32+:32];
        if (i_wr && i_addr == OFF_NCO0 + 4*k) sh[k/2][k%2*32+:32] = i_wdata;
      end
      if (i_rd && i_addr == OFF_SW_SYNC) rd = sw;
      if (i_rd && i_addr == OFF_SELF_SYN) rd = ss;
      if (i_wr && i_addr == OFF_SW_SYNC) begin
        ev |= i_wdata[0] && !sw && sel inside {0, 2};
        sw = i_wdata[0];
      end
      if (i_wr && i_addr == OFF_SELF_SYN) ss = i_wdata[0];
      if (i_wr && i_addr == OFF_CONTROL) {fr, sel} = {i_wdata[5], i_wdata[1:0]};
      if (ev) ac = sh;
      pl = ev;
    end
  end
  always @(negedge i_core_clk) if (i_reset_n) begin
    chk("phase", {ph[2], ph[1], ph[0]}, o_phase);
    chk("rdata", rd, o_rdata);
    chk("pulse", pl, o_sync_pulse);
  end
  initial begin
    {i_reset_n, i_wr, i_rd, i_ext_sync, i_addr, i_wdata, i_fast_words} = '0;
    void'($urandom(9));
    repeat (5) @(posedge i_core_clk);
    i_reset_n <= 1;
    @(posedge i_core_clk);
    // Words stay shadow-only here; datapath enable is kept low throughout.
    for (s = 0; s < 3; s++) begin
      rdr(OFF_NCO0 + 8*s);
      d = {$urandom, $urandom};
      wr(OFF_NCO0 + 8*s, d[31:0]);
      rdr(OFF_NCO0 + 8*s);
      wr(OFF_NCO0 + 8*s + 4, d[63:32]);
      rdr(OFF_NCO0 + 8*s + 4);
    end
    rdr(12'h310);
    for (s = 0; s < 4; s++) begin
      wr(OFF_CONTROL, s);
      wr(OFF_NCO0 + 4*(s%2), $urandom);
      wr(OFF_SW_SYNC, 0);
      wr(OFF_SW_SYNC, 1);
      rdr(OFF_SW_SYNC);
      wr(OFF_SW_SYNC, 1);
      idle(3);
      i_ext_sync <= 1;
      @(posedge i_core_clk) i_ext_sync <= 0;
      repeat (3) @(posedge i_core_clk);
    end
    wr(OFF_CONTROL, 32'h23);
    repeat (2) begin
      i_fast_words <= {6{$urandom}};
      wr(OFF_NCO0, $urandom);
      idle(4);
    end
    wr(OFF_CONTROL, 0);
    wr(OFF_SELF_SYN, 1);
    rdr(OFF_SELF_SYN);
    wr(OFF_NCO2, $urandom);
    wr(OFF_NCO1 + 4, $urandom);
    idle(600);
    give_verdict();
  end
endmodule // tb_nco_frequency_word_bank
